// ---- gpio_bank_defines.vh ----
/*
 Constants for the pin configuration bank, pins 1.4 to 2.6: register
 offsets, field positions, write masks and reset values.
 Assumes inclusion by the bank module only; holds definitions only.
*/
`ifndef GPIO_BANK_DEFINES_VH
`define GPIO_BANK_DEFINES_VH

////////////////////////////////////////////////////////////////////////////
// register offsets
`define OFS_PIN_1_4_CONFIG 8'h27
`define OFS_PIN_1_5_CONFIG 8'h28
`define OFS_PIN_1_6_CONFIG 8'h29
`define OFS_PIN_1_7_CONFIG 8'h2A
`define OFS_PIN_2_0_CONFIG 8'h2B
`define OFS_PIN_2_1_CONFIG 8'h2C
`define OFS_PIN_2_2_CONFIG 8'h2D
`define OFS_PIN_2_3_CONFIG 8'h2E
`define OFS_PIN_2_4_CONFIG 8'h2F
`define OFS_PIN_2_5_CONFIG 8'h30
`define OFS_PIN_2_6_CONFIG 8'h31
`define OFS_GROUP1_DATA 8'h4C
`define OFS_GROUP2_DATA 8'h4D

////////////////////////////////////////////////////////////////////////////
// field positions
`define BIT_DIR_IN 0
`define BIT_INVERT 1
`define BIT_ALT_LO 2
`define BIT_ALT_HI 3
`define BIT_OPEN_DRAIN 7

////////////////////////////////////////////////////////////////////////////
// reset value and implemented-bit masks
`define CFG_RESET 8'h01
`define MASK_ONE_BIT_ALT 8'h87
`define MASK_TWO_BIT_ALT 8'h8F
`define MASK_NO_ALT 8'h83

////////////////////////////////////////////////////////////////////////////
// alternate select codes
`define SEL_GPIO 2'h0
`define SEL_ALT1 2'h1
`define SEL_ALT2 2'h2
`define SEL_ALT3 2'h3

`endif

// ---- gpio_bank_sva.sv ----
/*
 Checker for the pin configuration bank, pins 1.4 to 2.6.
 Assumes binding to the bank top: one clock, async active-low reset.
*/
`default_nettype none
module gpio_bank_sva #(
	parameter int NUM_PINS = 11
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic [NUM_PINS-1:0] pin_out,
	input wire logic [NUM_PINS-1:0] pin_oe,
	input wire logic [3:0] xbus_data_out,
	input wire logic [3:0] xbus_data_oe,
	input wire logic floppy_drive_select_1_n,
	input wire logic floppy_motor_select_1_n,
	input wire logic xbus_read_strobe_n,
	input wire logic serial_irq_input_d
);
	logic [7:0] cfg_ff [11];
	logic [7:0] dat_ff;
	logic map_hit;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	assign map_hit = reg_addr >= 8'h27 && reg_addr <= 8'h31;
	// shadow of the config bytes and group 2 output data
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cfg_ff <= '{default: 8'h01};
			dat_ff <= 8'h00;
		end else if (reg_wr && map_hit) begin
			cfg_ff[reg_addr - 8'h27] <= reg_wdata;
		end else if (reg_wr && reg_addr == 8'h4D) begin
			dat_ff <= reg_wdata;
		end
	end
	////////////////////////////////////////
	a_rdata_idle: assert property (
		!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("rdata not idle");
	a_rsvd_zero: assert property (
		$past(reg_rd && map_hit) |-> reg_rdata[6:4] == 3'h0)
		else $error("reserved bits set");
	a_unmapped_zero: assert property (
		$past(reg_rd && !map_hit && reg_addr != 8'h4C && reg_addr != 8'h4D)
		|-> reg_rdata == 8'h00) else $error("unmapped read not zero");
	a_input_no_drive: assert property (
		$past(cfg_ff[8][0]) |-> !pin_oe[8]) else $error("input pin driven");
	a_push_pull: assert property (
		$past(cfg_ff[8][0] | cfg_ff[8][7]) == 1'b0 |-> pin_oe[8]
		&& pin_out[8] == $past(dat_ff[4] ^ cfg_ff[8][1]))
		else $error("push-pull output wrong");
	a_open_drain: assert property (
		$past(!cfg_ff[8][0] && cfg_ff[8][7]) |-> !pin_out[8]
		&& pin_oe[8] == !$past(dat_ff[4] ^ cfg_ff[8][1]))
		else $error("open-drain output wrong");
	a_read_strobe: assert property (
		$past(cfg_ff[9][2] && !cfg_ff[9][7]) |-> pin_oe[9]
		&& pin_out[9] == $past(xbus_read_strobe_n ^ cfg_ff[9][1]))
		else $error("read strobe not routed");
	a_drive_sel: assert property (
		$past(cfg_ff[4][3:2] == 2'h2 && !cfg_ff[4][7]) |-> pin_out[4]
		== $past(floppy_drive_select_1_n ^ cfg_ff[4][1]))
		else $error("drive select not routed");
	a_rsvd_select: assert property (
		$past(cfg_ff[4][3:2] == 2'h3 && cfg_ff[4][0]) |-> !pin_oe[4])
		else $error("reserved select drives pin");
	a_motor_sel: assert property (
		$past(cfg_ff[6][3:2] == 2'h3 && !cfg_ff[6][7]) |-> pin_out[6]
		== $past(floppy_motor_select_1_n ^ cfg_ff[6][1]))
		else $error("motor select not routed");
	a_xbus_data: assert property (
		$past(cfg_ff[0][2] && !cfg_ff[0][7] && xbus_data_oe[0]) |-> pin_oe[0]
		&& pin_out[0] == $past(xbus_data_out[0] ^ cfg_ff[0][1]))
		else $error("expansion data not routed");
	a_serial_off: assert property (
		!cfg_ff[7][2] [*4] |-> !serial_irq_input_d)
		else $error("serial irq while not routed");
endmodule
`default_nettype wire

// ---- gpio_pin_config_bank.v ----
/*
 Configuration and pin muxing for general purpose pins 1.4 to 2.6.
 Index 0..3 are pins 1.4..1.7, index 4..10 are pins 2.0..2.6.
 Assumes a single 25 MHz clock, reset_n driven by the standby power
 reset, pin inputs asynchronous to clk and peripheral signals on clk.
*/
// Implementation choice: the plain strobed port.
`include "gpio_bank_defines.vh"
`default_nettype none

module gpio_pin_config_bank #(
	parameter NUM_PINS = 11
) (
	input wire clk,
	input wire reset_n,
	// register bus
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	// pins
	input wire [NUM_PINS-1:0] pin_in,
	output reg [NUM_PINS-1:0] pin_out,
	output reg [NUM_PINS-1:0] pin_oe,
	// expansion bus data unit
	input wire [3:0] xbus_data_out,
	input wire [3:0] xbus_data_oe,
	output reg [3:0] xbus_data_in,
	// floppy and keyboard controller signals
	input wire floppy_drive_select_1_n,
	input wire floppy_motor_select_1_n,
	input wire kbc_port_pin_17,
	input wire kbc_port_pin_16,
	input wire kbc_port_pin_12,
	// interrupt inputs
	output reg [1:0] edge_irq_in,
	output reg serial_irq_input_d,
	// expansion bus strobes
	input wire xbus_read_strobe_n,
	input wire xbus_write_strobe_n
);

	// bit indices of the group 2 pins
	localparam IDX_2_0 = 4;
	localparam IDX_2_1 = 5;
	localparam IDX_2_2 = 6;
	localparam IDX_2_3 = 7;
	localparam IDX_2_4 = 8;
	localparam IDX_2_5 = 9;
	localparam IDX_2_6 = 10;

	integer i;

	// stored state
	reg [7:0] cfg_ff [0:NUM_PINS-1];
	reg [NUM_PINS-1:0] gpio_data_ff;
	reg [NUM_PINS-1:0] sync1_ff;
	reg [NUM_PINS-1:0] sync2_ff;
	reg [7:0] rdata_ff;

	// combinational values
	reg [NUM_PINS-1:0] alt_en;
	reg [NUM_PINS-1:0] alt_val;
	reg [NUM_PINS-1:0] alt_drive;
	reg [NUM_PINS-1:0] drive;
	reg [NUM_PINS-1:0] out_val;
	reg [NUM_PINS-1:0] in_val;
	reg [NUM_PINS-1:0] nxt_pin_out;
	reg [NUM_PINS-1:0] nxt_pin_oe;
	reg [7:0] nxt_rdata;
	reg [3:0] nxt_xbus_data_in;
	reg [1:0] nxt_edge_irq;
	reg nxt_serial_irq_d;
	reg cfg_hit;
	reg [3:0] cfg_idx;
	reg edge0_sel;
	reg edge1_sel;

	////////////////////////////////////////////////////////////////////////
	// slot of a configuration register, offset from the first one
	function [3:0] cfg_slot;
		input [7:0] addr;
		reg [7:0] offset;
		begin
			offset = addr - `OFS_PIN_1_4_CONFIG;
			cfg_slot = offset[3:0]; // range is checked by the caller
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// two-bit alternate select of a configuration byte
	function [1:0] sel_of;
		input [7:0] cfg;
		begin
			sel_of = cfg[`BIT_ALT_HI:`BIT_ALT_LO];
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// implemented bits of a pin's register
	function [7:0] impl_mask;
		input [3:0] idx;
		begin
			if (idx >= 4'd4 && idx <= 4'd6)
				impl_mask = `MASK_TWO_BIT_ALT;
			else if (idx == 4'd8)
				impl_mask = `MASK_NO_ALT;
			else
				impl_mask = `MASK_ONE_BIT_ALT;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// register index from address
	always @* begin
		cfg_hit = 1'b0;
		cfg_idx = 4'h0;
		if (reg_addr >= `OFS_PIN_1_4_CONFIG &&
			reg_addr <= `OFS_PIN_2_6_CONFIG) begin
			cfg_hit = 1'b1;
			cfg_idx = cfg_slot(reg_addr);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// configuration registers, masked writes
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (i = 0; i < NUM_PINS; i = i + 1)
				cfg_ff[i] <= `CFG_RESET;
		end else if (reg_wr && cfg_hit) begin
			// reserved bits never stored
			cfg_ff[cfg_idx] <= reg_wdata & impl_mask(cfg_idx);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// gpio output data registers
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			gpio_data_ff <= {NUM_PINS{1'b0}};
		end else if (reg_wr) begin
			// group 1 data sits in the upper nibble
			if (reg_addr == `OFS_GROUP1_DATA)
				gpio_data_ff[3:0] <= reg_wdata[7:4];
			else if (reg_addr == `OFS_GROUP2_DATA)
				gpio_data_ff[10:4] <= reg_wdata[6:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read data, valid the cycle after the strobe
	always @* begin
		nxt_rdata = 8'h00;
		if (reg_rd) begin
			if (cfg_hit)
				nxt_rdata = cfg_ff[cfg_idx];
			else if (reg_addr == `OFS_GROUP1_DATA)
				nxt_rdata = {in_val[3:0], 4'h0};
			else if (reg_addr == `OFS_GROUP2_DATA)
				nxt_rdata = {1'b0, in_val[10:4]};
		end
	end

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			rdata_ff <= 8'h00;
		else
			rdata_ff <= nxt_rdata;
	end

	always @* begin
		reg_rdata = rdata_ff;
	end

	////////////////////////////////////////////////////////////////////////
	// two-stage pin synchroniser
	// first stage is read by the second stage only
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sync1_ff <= {NUM_PINS{1'b0}};
			sync2_ff <= {NUM_PINS{1'b0}};
		end else begin
			sync1_ff <= pin_in;
			sync2_ff <= sync1_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// alternate function select per pin
	always @* begin
		alt_en = {NUM_PINS{1'b0}};
		alt_val = {NUM_PINS{1'b0}};
		alt_drive = {NUM_PINS{1'b0}};
		// expansion data bits 4..7, direction from the bus unit
		for (i = 0; i < 4; i = i + 1) begin
			if (cfg_ff[i][`BIT_ALT_LO]) begin
				alt_en[i] = 1'b1;
				alt_val[i] = xbus_data_out[i];
				alt_drive[i] = xbus_data_oe[i];
			end
		end
		// pin 2.0; code 11 falls back to plain gpio
		case (sel_of(cfg_ff[IDX_2_0]))
		`SEL_ALT2: begin
			alt_en[IDX_2_0] = 1'b1;
			alt_val[IDX_2_0] = floppy_drive_select_1_n;
			alt_drive[IDX_2_0] = 1'b1;
		end
		`SEL_ALT1: begin
			alt_en[IDX_2_0] = 1'b1;
			alt_val[IDX_2_0] = kbc_port_pin_17;
			alt_drive[IDX_2_0] = 1'b1;
		end
		default: begin
			alt_en[IDX_2_0] = 1'b0;
		end
		endcase
		// pin 2.1
		case (sel_of(cfg_ff[IDX_2_1]))
		`SEL_ALT3: begin
			alt_en[IDX_2_1] = 1'b1;
			alt_val[IDX_2_1] = kbc_port_pin_12;
			alt_drive[IDX_2_1] = 1'b1;
		end
		`SEL_ALT2: begin
			alt_en[IDX_2_1] = 1'b1; // edge irq 0 is input only
		end
		`SEL_ALT1: begin
			alt_en[IDX_2_1] = 1'b1;
			alt_val[IDX_2_1] = kbc_port_pin_16;
			alt_drive[IDX_2_1] = 1'b1;
		end
		default: begin
			alt_en[IDX_2_1] = 1'b0;
		end
		endcase
		// pin 2.2
		case (sel_of(cfg_ff[IDX_2_2]))
		`SEL_ALT3: begin
			alt_en[IDX_2_2] = 1'b1;
			alt_val[IDX_2_2] = floppy_motor_select_1_n;
			alt_drive[IDX_2_2] = 1'b1;
		end
		`SEL_ALT2: begin
			alt_en[IDX_2_2] = 1'b1; // edge irq 1 is input only
		end
		`SEL_ALT1: begin
			alt_en[IDX_2_2] = 1'b1;
			alt_val[IDX_2_2] = kbc_port_pin_12;
			alt_drive[IDX_2_2] = 1'b1;
		end
		default: begin
			alt_en[IDX_2_2] = 1'b0;
		end
		endcase
		// pin 2.3, serial interrupt input only
		alt_en[IDX_2_3] = cfg_ff[IDX_2_3][`BIT_ALT_LO];
		// pin 2.4 has no alternate; direction alone decides
		alt_en[IDX_2_4] = 1'b0;
		// pin 2.5 and 2.6, expansion strobes
		if (cfg_ff[IDX_2_5][`BIT_ALT_LO]) begin
			alt_en[IDX_2_5] = 1'b1;
			alt_val[IDX_2_5] = xbus_read_strobe_n;
			alt_drive[IDX_2_5] = 1'b1;
		end
		if (cfg_ff[IDX_2_6][`BIT_ALT_LO]) begin
			alt_en[IDX_2_6] = 1'b1;
			alt_val[IDX_2_6] = xbus_write_strobe_n;
			alt_drive[IDX_2_6] = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// direction, polarity and driver type per pin
	always @* begin
		for (i = 0; i < NUM_PINS; i = i + 1) begin
			// gpio mode follows the direction bit
			drive[i] = alt_en[i] ? alt_drive[i] :
				~cfg_ff[i][`BIT_DIR_IN];
			out_val[i] = (alt_en[i] ? alt_val[i] : gpio_data_ff[i]) ^
				cfg_ff[i][`BIT_INVERT];
			in_val[i] = sync2_ff[i] ^ cfg_ff[i][`BIT_INVERT];
			if (cfg_ff[i][`BIT_OPEN_DRAIN]) begin
				// open drain only pulls low
				nxt_pin_out[i] = 1'b0;
				nxt_pin_oe[i] = drive[i] & ~out_val[i];
			end else begin
				nxt_pin_out[i] = out_val[i];
				nxt_pin_oe[i] = drive[i];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// edge interrupt routing, input only
	always @* begin
		edge0_sel = (sel_of(cfg_ff[IDX_2_1]) == `SEL_ALT2);
		edge1_sel = (sel_of(cfg_ff[IDX_2_2]) == `SEL_ALT2);
	end

	////////////////////////////////////////////////////////////////////////
	// inputs to peripherals, idle low when not routed
	always @* begin
		for (i = 0; i < 4; i = i + 1)
			nxt_xbus_data_in[i] = alt_en[i] & in_val[i];
		nxt_edge_irq[0] = edge0_sel & in_val[IDX_2_1];
		nxt_edge_irq[1] = edge1_sel & in_val[IDX_2_2];
		nxt_serial_irq_d = alt_en[IDX_2_3] & in_val[IDX_2_3];
	end

	////////////////////////////////////////////////////////////////////////
	// registered pin outputs, released during reset
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pin_out <= {NUM_PINS{1'b0}};
			pin_oe <= {NUM_PINS{1'b0}};
		end else begin
			pin_out <= nxt_pin_out;
			pin_oe <= nxt_pin_oe;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registered peripheral inputs, low during reset
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			xbus_data_in <= 4'h0;
			edge_irq_in <= 2'h0;
			serial_irq_input_d <= 1'b0;
		end else begin
			xbus_data_in <= nxt_xbus_data_in;
			edge_irq_in <= nxt_edge_irq;
			serial_irq_input_d <= nxt_serial_irq_d;
		end
	end

endmodule

`default_nettype wire

// ---- gpio_pin_world.sv ----
/*
 Board side of the pins: each pin shows the bank's level when driven.
 Assumes the bench gives a board level for every released pin.
*/
`default_nettype none
module gpio_pin_world (
	input wire logic [10:0] pin_out,
	input wire logic [10:0] pin_oe,
	input wire logic [10:0] ext_level,
	output logic [10:0] pin_in
);
	timeunit 1ns;
	timeprecision 1ns;
	// driven pins carry the bank level, released ones the board level
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule
`default_nettype wire

// ---- test_gpio_pin_config_bank_1_2.sv ----
/*
 Self-checking bench for the pin configuration bank.
 Assumes the bank, its checker and the pin model compile before it.
*/
`default_nettype none
module test_gpio_pin_config_bank_1_2;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, reset_n, reg_wr, reg_rd, inv, e, s;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val, m, per;
	logic [10:0] pin_in, pin_out, pin_oe, ext_level;
	logic [3:0] xd_out, xd_oe, xd_in;
	logic [1:0] edge_irq;
	logic ser_irq;
	int mismatches, checks;
	logic [31:0] seed = 32'h0000_0041;
	int mask_q[$] = '{135, 135, 135, 135, 143, 143, 143, 135, 131, 135, 135};
	logic [7:0] od_q[$] = '{8'h00, 8'h02, 8'h80, 8'h82};
	logic [7:0] alt_a[$] = '{8'h2B, 8'h2B, 8'h2C, 8'h2C, 8'h2D, 8'h2D,
		8'h30, 8'h31, 8'h27, 8'h2C, 8'h2D, 8'h2E, 8'h2B};
	logic [7:0] alt_v[$] = '{8'h09, 8'h05, 8'h0D, 8'h05, 8'h0D, 8'h05,
		8'h05, 8'h05, 8'h05, 8'h09, 8'h09, 8'h05, 8'h0D};
	int alt_p[$] = '{4, 4, 5, 5, 6, 6, 9, 10, 0, 5, 6, 7, 4};
	int alt_s[$] = '{1, 3, 5, 4, 2, 5, 6, 7, 0, 8, 9, 10, 12};
	gpio_pin_config_bank dut_u (.clk(clk), .reset_n(reset_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe(pin_oe), .xbus_data_out(xd_out),
		.xbus_data_oe(xd_oe), .xbus_data_in(xd_in),
		.floppy_drive_select_1_n(per[1]), .floppy_motor_select_1_n(per[2]),
		.kbc_port_pin_17(per[3]), .kbc_port_pin_16(per[4]),
		.kbc_port_pin_12(per[5]), .edge_irq_in(edge_irq),
		.serial_irq_input_d(ser_irq), .xbus_read_strobe_n(per[6]),
		.xbus_write_strobe_n(per[7]));
	gpio_pin_world world_u (.pin_out(pin_out), .pin_oe(pin_oe),
		.ext_level(ext_level), .pin_in(pin_in));
	////////////////////////////////////////
	// free-running 25 MHz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	task automatic cmp(string what, logic [7:0] seen, logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 rd_val = reg_rdata;
	endtask
	task automatic settle();
		repeat (5) @(posedge clk);
		#1;
	endtask
	task automatic do_reset();
		reset_n <= 1'b0;
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// main sequence: registers, pin input, pin output, alternates
	initial begin
		{reset_n, reg_wr, reg_rd, reg_addr, reg_wdata, per} = '0;
		{ext_level, xd_out} = '0;
		xd_oe = 4'hF;
		do_reset();
		for (int i = 0; i < 11; i++) begin
			rd(8'(39 + i));
			cmp("cfg reset", rd_val, 8'h01);
			m = rnd();
			wr(8'(39 + i), m);
			rd(8'(39 + i));
			cmp("cfg rw", rd_val, m & 8'(mask_q[i]));
		end
		rd(8'h50);
		cmp("unmapped", rd_val, 8'h00);
		$display("test registers done");
		do_reset();
		ext_level <= 11'({rnd(), rnd()});
		wr(8'h2F, 8'h03);
		settle();
		rd(8'h4C);
		cmp("group1 in", rd_val, {ext_level[3:0], 4'h0});
		rd(8'h4D);
		cmp("group2 in", rd_val, {1'b0, ext_level[10:4]} ^ 8'h10);
		foreach (od_q[k]) begin
			m = rnd();
			wr(8'h4D, m);
			wr(8'h2F, od_q[k]);
			settle();
			e = m[4] ^ od_q[k][1];
			cmp("oe 2.4", 8'(pin_oe[8]), od_q[k][7] ? 8'(!e) : 8'h01);
			cmp("out 2.4", 8'(pin_out[8]), od_q[k][7] ? 8'h00 : 8'(e));
		end
		$display("test pin direction done");
		for (int r = 0; r < 2; r++) foreach (alt_a[k]) begin
			m = rnd();
			per <= m;
			xd_out <= m[3:0];
			ext_level <= 11'({rnd(), rnd()});
			inv = m[7];
			wr(alt_a[k], alt_v[k] | {6'h00, inv, 1'b0});
			settle();
			e = (alt_s[k] < 8 ? m[alt_s[k] % 8] : ext_level[alt_p[k]]) ^ inv;
			case (alt_s[k])
				8: s = edge_irq[0];
				9: s = edge_irq[1];
				10: s = ser_irq;
				default: s = pin_out[alt_p[k]];
			endcase
			cmp("alt oe", 8'(pin_oe[alt_p[k]]), 8'(alt_s[k] < 8));
			if (alt_s[k] != 12)
				cmp("alt value", 8'(s), 8'(e));
			if (alt_s[k] == 0)
				cmp("xbus in", 8'(xd_in[0]), 8'(m[0]));
		end
		$display("test alternates done");
		summarize();
	end
endmodule
bind gpio_pin_config_bank gpio_bank_sva #(.NUM_PINS(NUM_PINS)) chk_u (.*);
`default_nettype wire
